//--- design/fec_regs.svh
// Purpose: register map and reset values of the far-end block error
//          and receive slip monitor counters
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   printed offsets are word indices; byte address is index * 4
`ifndef FEC_REGS_SVH
`define FEC_REGS_SVH

// ------------------------------------------------------------------
// register indices
// ------------------------------------------------------------------
`define FEC_IDX_FAR_HIGH 16'h0907
`define FEC_IDX_FAR_LOW 16'h0908
`define FEC_IDX_SLIP 16'h090a
`define FEC_IDX_CTRL 16'h090f

// ------------------------------------------------------------------
// byte addresses on the bus
// ------------------------------------------------------------------
`define FEC_ADDR_FAR_HIGH (16'(`FEC_IDX_FAR_HIGH * 4))
`define FEC_ADDR_FAR_LOW (16'(`FEC_IDX_FAR_LOW * 4))
`define FEC_ADDR_SLIP (16'(`FEC_IDX_SLIP * 4))
`define FEC_ADDR_CTRL (16'(`FEC_IDX_CTRL * 4))

// ------------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------------
`define FEC_FAR_WIDTH 16
`define FEC_SLIP_WIDTH 8
`define FEC_CTRL_FAR_EN_BIT 0
`define FEC_CTRL_SLIP_EN_BIT 1
`define FEC_CTRL_RESET 2'h3
`define FEC_COUNT_RESET 16'h0000

`endif

//--- design/fec_pkg.sv
// Purpose: shared types of the far-end and slip monitor
// Assumes: nothing
// Notes:   constants live in fec_regs.svh
package fec_pkg;

    // which register an APB transfer addresses
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_FAR_HIGH,
        SEL_FAR_LOW,
        SEL_SLIP,
        SEL_CTRL
    } fec_sel_type;

    typedef logic [7:0] fec_byte_type;

endpackage : fec_pkg

//--- design/fec_count_if.sv
// Purpose: carries one monitor counter between the bus logic and the
//          counter module
// Assumes: single clock domain
// Notes:   take subtracts amount in the same cycle as inc adds one
`timescale 1ns/1ps
`default_nettype none

interface fec_count_if #(
    parameter int WIDTH = 8
);
    logic inc;
    logic take;
    logic [WIDTH-1:0] amount;
    logic [WIDTH-1:0] value;

    modport counter (
        input inc,
        input take,
        input amount,
        output value
    );

    modport user (
        output inc,
        output take,
        output amount,
        input value
    );
endinterface : fec_count_if

`default_nettype wire

//--- design/fec_event_counter.sv
// Purpose: saturating event counter with read-and-subtract clearing
// Assumes: amount never exceeds value at the cycle of take
// Notes:   an event in the clearing cycle is kept, never lost
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"

module fec_event_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    fec_count_if.counter cnt
);

    logic [WIDTH-1:0] remain;
    logic [WIDTH-1:0] value_d;

    // ------------------------------------------------------------------
    // next value
    // ------------------------------------------------------------------
    // subtract what software saw, then add the new event, saturating
    always_comb begin
        remain = cnt.take ? cnt.value - cnt.amount : cnt.value;
        if (cnt.inc && remain != {WIDTH{1'b1}}) begin
            value_d = remain + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            value_d = remain;
        end
    end

    // counter register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt.value <= WIDTH'(`FEC_COUNT_RESET);
        end else begin
            cnt.value <= value_d;
        end
    end

endmodule : fec_event_counter

`default_nettype wire

//--- design/fec_far_end_slip_mon.sv
// Purpose: far-end block error and receive slip monitor counters
//          behind an APB slave
// Assumes: event strobes are one-cycle pulses on clk_sys
// Notes:   all counters clear on read; read the high byte first
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"

module fec_far_end_slip_mon (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eBitStrobe,
    input wire logic eBitValue,
    input wire logic fasSyncLoss,
    input wire logic crcSyncLoss,
    input wire logic slipRepeat,
    input wire logic slipDrop
);

    fec_count_if #(.WIDTH(`FEC_FAR_WIDTH)) farIf ();
    fec_count_if #(.WIDTH(`FEC_SLIP_WIDTH)) slipIf ();

    fec_pkg::fec_sel_type sel_q;
    fec_pkg::fec_sel_type selNow;
    logic [1:0] ctrl_q;
    logic [15:0] shownFar_q;
    logic [7:0] shownSlip_q;
    fec_pkg::fec_byte_type snapLow_q;
    logic snapArmed_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] readNow;
    logic setupPhase;
    logic complete;
    logic readDone;
    logic writeDone;

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    fec_event_counter #(.WIDTH(`FEC_FAR_WIDTH)) farCounter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cnt(farIf.counter)
    );

    fec_event_counter #(.WIDTH(`FEC_SLIP_WIDTH)) slipCounter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cnt(slipIf.counter)
    );

    // far-end events: zero E-bit, gated by sync loss
    // zero bit, sync gate
    assign farIf.inc = eBitStrobe && !eBitValue && !fasSyncLoss
        && !crcSyncLoss && ctrl_q[`FEC_CTRL_FAR_EN_BIT];

    // slip events: repeated or dropped frame counts once
    // one per slip
    assign slipIf.inc = (slipRepeat || slipDrop)
        && ctrl_q[`FEC_CTRL_SLIP_EN_BIT];

    // ------------------------------------------------------------------
    // apb phases and decode
    // ------------------------------------------------------------------
    assign setupPhase = psel && !penable;
    assign complete = psel && penable && pready_q;
    assign readDone = complete && !pwrite;
    assign writeDone = complete && pwrite;

    // address decode
    always_comb begin
        unique case (paddr)
            `FEC_ADDR_FAR_HIGH: selNow = fec_pkg::SEL_FAR_HIGH;
            `FEC_ADDR_FAR_LOW: selNow = fec_pkg::SEL_FAR_LOW;
            `FEC_ADDR_SLIP: selNow = fec_pkg::SEL_SLIP;
            `FEC_ADDR_CTRL: selNow = fec_pkg::SEL_CTRL;
            default: selNow = fec_pkg::SEL_NONE;
        endcase
    end

    // read data mux, evaluated in the setup cycle
    always_comb begin
        readNow = 32'h0000_0000;
        unique case (selNow)
            fec_pkg::SEL_FAR_HIGH: readNow[7:0] = farIf.value[15:8];
            fec_pkg::SEL_FAR_LOW: readNow[7:0] =
                snapArmed_q ? snapLow_q : farIf.value[7:0];
            fec_pkg::SEL_SLIP: readNow[7:0] = slipIf.value;
            fec_pkg::SEL_CTRL: readNow[1:0] = ctrl_q;
            fec_pkg::SEL_NONE: readNow = 32'h0000_0000;
        endcase
    end

    // no wait state: ready rises in the first access cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setupPhase;
        end
    end

    // latch select, answer and error at setup
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sel_q <= fec_pkg::SEL_NONE;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setupPhase) begin
            sel_q <= selNow;
            prdata_q <= pwrite ? 32'h0000_0000 : readNow;
            pslverr_q <= (selNow == fec_pkg::SEL_NONE);
        end
    end

    // values the reader sees, frozen at setup
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shownFar_q <= `FEC_COUNT_RESET;
            shownSlip_q <= 8'h00;
        end else if (setupPhase) begin
            shownFar_q <= farIf.value;
            shownSlip_q <= slipIf.value;
        end
    end

    // ------------------------------------------------------------------
    // clear-on-read effects, only at the completing edge
    // ------------------------------------------------------------------
    // subtract seen count
    assign farIf.take = readDone && sel_q == fec_pkg::SEL_FAR_HIGH;
    assign farIf.amount = shownFar_q;
    assign slipIf.take = readDone && sel_q == fec_pkg::SEL_SLIP;
    assign slipIf.amount = shownSlip_q;

    // low byte snapshot armed by high read, released by low read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            snapLow_q <= 8'h00;
            snapArmed_q <= 1'b0;
        end else if (farIf.take) begin
            snapLow_q <= shownFar_q[7:0];
            snapArmed_q <= 1'b1;
        end else if (readDone && sel_q == fec_pkg::SEL_FAR_LOW) begin
            snapLow_q <= 8'h00;
            snapArmed_q <= 1'b0;
        end
    end

    // control register: counting enables
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q <= `FEC_CTRL_RESET;
        end else if (writeDone && sel_q == fec_pkg::SEL_CTRL && pstrb[0]) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule : fec_far_end_slip_mon

`default_nettype wire

//--- tb/fec_mon_monitor.sv
// Purpose: port checks of the far-end and slip monitor
// Assumes: one-cycle APB access after each setup
// Notes: bound to every instance of the monitor top
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"
module fec_mon_monitor (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic eBitStrobe,
    input wire logic eBitValue,
    input wire logic fasSyncLoss,
    input wire logic crcSyncLoss,
    input wire logic slipRepeat,
    input wire logic slipDrop
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    localparam logic [15:0] HI = `FEC_ADDR_FAR_HIGH;
    localparam logic [15:0] SL = `FEC_ADDR_SLIP;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // setup cycle and decode helpers
    wire logic setup = psel && !penable;
    wire logic slipEv = slipRepeat || slipDrop;
    wire logic mapped = paddr inside {HI, SL, `FEC_ADDR_FAR_LOW,
                                      `FEC_ADDR_CTRL};
    AST_RDY:
        assert property (setup |=> pready)
        else $error("no ready after setup");
    AST_PULSE:
        assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_IDLE:
        assert property (!psel |=> !pready)
        else $error("ready without select");
    AST_BITS:
        assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_HOLD:
        assert property (!setup |=> $stable(prdata))
        else $error("read data moved outside setup");
    AST_UNMAP:
        assert property (setup && !mapped |=> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    AST_SLIP_CLR:
        assert property ((setup && paddr == SL && !pwrite && !slipEv)
            ##1 !slipEv [*2] ##1 (setup && paddr == SL && !pwrite)
            |=> prdata == 32'h0) else $error("slip count not cleared");
    AST_FAR_CLR:
        assert property ((setup && paddr == HI && !pwrite && !eBitStrobe)
            ##1 !eBitStrobe [*2] ##1 (setup && paddr == HI && !pwrite)
            |=> prdata == 32'h0) else $error("far count not cleared");
    // main scenarios seen
    cover property (setup && paddr == HI && !pwrite);
    cover property (setup && paddr == SL && !pwrite);
    cover property (pready && pslverr);
endmodule : fec_mon_monitor
bind fec_far_end_slip_mon fec_mon_monitor fec_mon_monitor_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eBitStrobe(eBitStrobe), .eBitValue(eBitValue),
    .fasSyncLoss(fasSyncLoss), .crcSyncLoss(crcSyncLoss),
    .slipRepeat(slipRepeat), .slipDrop(slipDrop));
`default_nettype wire

//--- tb/tb_fec_far_end_slip_mon.sv
// Purpose: directed scenarios for the monitor counters
// Assumes: one-cycle APB access, one-cycle event strobes
// Notes: expected counts worked out from the strobes sent
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin \
    error_cnt++; $display("[ERR] %0t %h %h", $time, a, e); end end
`define RC(a, e) begin apb(1'b0, a, 32'h0); `CHK(rdat, e) end
module tb_fec_far_end_slip_mon;
    // ----------------------------------------------------------------
    // stimulus and scenarios
    // ----------------------------------------------------------------
    localparam logic [15:0] HI = `FEC_ADDR_FAR_HIGH;
    localparam logic [15:0] LO = `FEC_ADDR_FAR_LOW;
    localparam logic [15:0] SL = `FEC_ADDR_SLIP;
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'h1;
    logic pready, pslverr, rerr;
    logic eBitStrobe = 1'b0, eBitValue = 1'b0, fasSyncLoss = 1'b0;
    logic crcSyncLoss = 1'b0, slipRepeat = 1'b0, slipDrop = 1'b0;
    int error_cnt = 0, checked = 0;
    fec_far_end_slip_mon fec_far_end_slip_mon_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eBitStrobe(eBitStrobe),
        .eBitValue(eBitValue), .fasSyncLoss(fasSyncLoss),
        .crcSyncLoss(crcSyncLoss), .slipRepeat(slipRepeat),
        .slipDrop(slipDrop));
    // 100 ns clock
    initial forever #50 clk_sys = ~clk_sys;
    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // one APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // k: 0 zero E-bit, 1 one E-bit, 2 repeat, 4 drop, 6 both
    task automatic ev(input int num, input logic [2:0] k);
        repeat (num) begin
            @(posedge clk_sys);
            eBitStrobe <= (k < 3'd2);
            eBitValue <= k[0];
            slipRepeat <= k[1];
            slipDrop <= k[2];
            @(posedge clk_sys);
            eBitStrobe <= 1'b0;
            slipRepeat <= 1'b0;
            slipDrop <= 1'b0;
        end
    endtask : ev
    task automatic t_reset;
        `RC(`FEC_ADDR_CTRL, 32'h3)
        `RC(HI, 32'h0)
        `RC(LO, 32'h0)
        `RC(SL, 32'h0)
    endtask : t_reset
    // zero E-bits count, ones and sync loss do not
    task automatic t_gate;
        ev(3, 3'd0);
        ev(2, 3'd1);
        fasSyncLoss <= 1'b1;
        ev(2, 3'd0);
        fasSyncLoss <= 1'b0;
        crcSyncLoss <= 1'b1;
        ev(1, 3'd0);
        crcSyncLoss <= 1'b0;
        `RC(HI, 32'h0)
        `RC(LO, 32'h3)
        `RC(HI, 32'h0)
        `RC(HI, 32'h0)
        `RC(LO, 32'h0)
    endtask : t_gate
    // 300 events, then one between the high and low reads
    task automatic t_wide;
        ev(300, 3'd0);
        `RC(HI, 32'h1)
        ev(1, 3'd0);
        `RC(LO, 32'h2c)
        `RC(HI, 32'h0)
        `RC(LO, 32'h1)
    endtask : t_wide
    // low reads alone never clear
    task automatic t_low;
        ev(2, 3'd0);
        `RC(LO, 32'h2)
        `RC(LO, 32'h2)
        `RC(HI, 32'h0)
        `RC(LO, 32'h2)
        `RC(LO, 32'h0)
    endtask : t_low
    task automatic t_slip;
        ev(2, 3'd2);
        ev(1, 3'd4);
        ev(1, 3'd6);
        `RC(SL, 32'h4)
        `RC(SL, 32'h0)
        ev(260, 3'd4);
        `RC(SL, 32'hff)
    endtask : t_slip
    // counting enables: off stops both, masked write ignored
    task automatic t_ctrl;
        apb(1'b1, `FEC_ADDR_CTRL, 32'h0);
        `RC(`FEC_ADDR_CTRL, 32'h0)
        ev(1, 3'd0);
        ev(1, 3'd2);
        `RC(HI, 32'h0)
        `RC(LO, 32'h0)
        `RC(SL, 32'h0)
        pstrb <= 4'h0;
        apb(1'b1, `FEC_ADDR_CTRL, 32'h3);
        pstrb <= 4'h1;
        `RC(`FEC_ADDR_CTRL, 32'h0)
        apb(1'b1, `FEC_ADDR_CTRL, 32'h3);
        `RC(`FEC_ADDR_CTRL, 32'h3)
        ev(1, 3'd0);
        `RC(HI, 32'h0)
        `RC(LO, 32'h1)
    endtask : t_ctrl
    // unmapped read and write to a counter
    task automatic t_bad;
        apb(1'b0, 16'h0004, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdat, 32'h0)
        ev(1, 3'd2);
        apb(1'b1, SL, 32'h55);
        `RC(SL, 32'h1)
    endtask : t_bad
    // reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_gate();
        t_wide();
        t_low();
        t_slip();
        t_ctrl();
        t_bad();
        wrap_up();
    end
endmodule : tb_fec_far_end_slip_mon
`default_nettype wire
